// ### rtl/emap_pkg.sv
/*
 * shared constants, carriers and helper functions of the internal/auxiliary
 * ram map with error correction.
 * assumes a single core clock and a 32-bit avalon-mm register slave.
 */
`default_nettype none

package emap_pkg;

    // register byte offsets on the avalon-mm slave
    localparam logic [3:0] OFS_PROT_CTRL  = 4'h0;
    localparam logic [3:0] OFS_SYS_CTRL   = 4'h4;
    localparam logic [3:0] OFS_PROT_STAT  = 4'h8;
    localparam logic [3:0] OFS_ERR_ADDR   = 4'hc;

    // field positions
    localparam int unsigned PCTL_IPROT_BIT = 0;
    localparam int unsigned PCTL_XPROT_LSB = 1;
    localparam int unsigned PCTL_IRQEN_BIT = 3;
    localparam int unsigned SCTL_AUX_RAM_MAP_ENABLE_BIT  = 0;
    localparam int unsigned EADDR_AUX_BIT  = 8;

    // values after reset
    localparam logic [3:0] PROT_CTRL_RST  = 4'h0;
    localparam logic       SYS_CTRL_RST   = 1'b0;
    localparam logic [1:0] ERR_FLAGS_RST  = 2'h0;
    localparam logic [8:0] ERR_ADDR_RST   = 9'h000;

    // memory map figures
    localparam logic [7:0] UPPER_BASE     = 8'h80;
    localparam logic [3:0] BIT_AREA_HI    = 4'h2;
    localparam logic [7:0] AUX_PAGE       = 8'h00;

    typedef enum logic [1:0] {
        ACC_DIRECT   = 2'h0,
        ACC_INDIRECT = 2'h1,
        ACC_BANKREG  = 2'h2,
        ACC_BIT      = 2'h3
    } emap_acc_t;

    typedef struct packed {
        logic       valid;
        logic       we;
        emap_acc_t  kind;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       bit_val;
    } emap_int_req_t;

    typedef struct packed {
        logic        valid;
        logic        we;
        logic        via_ri;
        logic [15:0] addr;
        logic [7:0]  page;
        logic [7:0]  wdata;
    } emap_x_req_t;

    // hamming(12,8) plus overall parity, five check bits in the low end
    function automatic logic [7:0] emap_ecc_encode(input logic [7:0] d);
        logic p1;
        logic p2;
        logic p4;
        logic p8;
        logic p0;
        p1 = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
        p2 = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
        p4 = d[1] ^ d[2] ^ d[3] ^ d[7];
        p8 = d[4] ^ d[5] ^ d[6] ^ d[7];
        p0 = ^{d, p8, p4, p2, p1};
        return {3'h0, p0, p8, p4, p2, p1};
    endfunction : emap_ecc_encode

    // upper half folds onto the lower half while protection holds codes there
    function automatic logic [7:0] emap_remap(input logic [7:0] a, input logic prot);
        return prot ? {1'b0, a[6:0]} : a;
    endfunction : emap_remap

endpackage : emap_pkg

`default_nettype wire

// ### rtl/emap_secded.sv
/*
 * combinational single-correct double-detect check of one stored byte.
 * assumes the code byte was produced by emap_ecc_encode.
 */
`default_nettype none

module emap_secded
    import emap_pkg::*;
(
    input  wire logic       i_en,
    input  wire logic [7:0] i_data,
    input  wire logic [7:0] i_code,
    output logic      [7:0] o_data,
    output logic            o_single,
    output logic            o_double
);

    logic [7:0] recomputed;
    logic [3:0] syndrome;
    logic       parity_bad;
    logic [7:0] flip;

    assign recomputed = emap_ecc_encode(i_data);
    assign syndrome   = recomputed[3:0] ^ i_code[3:0];
    assign parity_bad = ^{i_data, i_code[4:0]};

    always_comb begin
        flip = 8'h00;
        unique case (syndrome)
            4'h3:    flip = 8'h01;
            4'h5:    flip = 8'h02;
            4'h6:    flip = 8'h04;
            4'h7:    flip = 8'h08;
            4'h9:    flip = 8'h10;
            4'ha:    flip = 8'h20;
            4'hb:    flip = 8'h40;
            4'hc:    flip = 8'h80;
            default: flip = 8'h00;
        endcase
    end

    // odd parity means one flip; even parity with a syndrome means two
    assign o_single = i_en & parity_bad;
    assign o_double = i_en & ~parity_bad & (syndrome != 4'h0);
    assign o_data   = (i_en & parity_bad) ? (i_data ^ flip) : i_data;

endmodule : emap_secded

`default_nettype wire

// ### rtl/emap_top.sv
/*
 * internal 256-byte ram, auxiliary 256-byte ram and external address map
 * of the core, with optional error correction, error capture and request.
 * assumes the core presents one request per cycle on the core clock and
 * that software reaches the control registers over avalon-mm.
 */
// Our own choices: the address map and the Avalon-MM interface to the registers.
`default_nettype none

// Notes on behaviour
// - program fetches external, read-only, store strobe
// - external data read/write strobes, separate space
// - data space paged, 64 KB pages
// - program space paged, 32 KB pages
// - direct above 7F is special-register space
// - four register banks chosen by bank bits
// - bits 00-7F live in bytes 20-2F
// - bytes 30-7F direct and indirect
// - bytes 80-FF indirect only
// - internal protect-enable bit switches correction on
// - protected upper half folds to modulo 80
// - code stored at X+80, read corrects data
// - errors set flags, capture address, request
// - protection adds no access cycles
// - aux ram at external 0000-00FF, data only
// - map bit routes pointer page 0 and register-indirect
// - mapped aux ram hides external 0000-00FF
// - aux protect bits enable aux correction, folding
// - aux errors share flags, address, request
module emap_top
    import emap_pkg::*;
#(
    parameter int unsigned RAM_BYTES = 256
) (
    input  wire logic          i_clk,
    input  wire logic          i_rst_b,
    input  wire logic [3:0]    i_avs_address,
    input  wire logic          i_avs_read,
    input  wire logic          i_avs_write,
    input  wire logic [31:0]   i_avs_writedata,
    input  wire logic [3:0]    i_avs_byteenable,
    output logic      [31:0]   o_avs_readdata,
    output logic               o_avs_waitrequest,
    input  wire emap_int_req_t i_int_req,
    input  wire logic          i_bank_select_hi,
    input  wire logic          i_bank_select_lo,
    output logic      [7:0]    o_int_rdata,
    output logic               o_int_bit,
    output logic               o_int_rvalid,
    output logic               o_sfr_access,
    input  wire emap_x_req_t   i_x_req,
    output logic      [7:0]    o_x_rdata,
    output logic               o_x_rvalid,
    output logic               o_ext_rd_b,
    output logic               o_ext_wr_b,
    output logic      [23:0]   o_ext_addr,
    output logic      [7:0]    o_ext_wdata,
    input  wire logic          i_p_req,
    input  wire logic [7:0]    i_p_page,
    input  wire logic [15:0]   i_p_addr,
    output logic               o_program_store_strobe_b,
    output logic      [22:0]   o_prog_addr,
    output logic               o_mem_err_irq
);

    if (RAM_BYTES != 256) begin : g_size_check
        $error("RAM_BYTES must be 256: the fold to modulo 80 assumes it");
    end

    logic [7:0] iram_ff [0:255];
    logic [7:0] aux_ram_ff [0:255];

    logic       iprot_ff;
    logic [1:0] xprot_ff;
    logic       irqen_ff;
    logic       aux_ram_map_enable_ff;
    logic [1:0] flags_ff;
    logic [8:0] eaddr_ff;
    logic       wait_ff;
    logic [31:0] rdata_ff;

    logic       xprot;
    logic [7:0] log_addr;
    logic       int_sfr;
    logic [7:0] iphys;
    logic [7:0] icode_addr;
    logic [7:0] iread;
    logic       isingle;
    logic       idouble;
    logic [7:0] iwbyte;
    logic       iacc;
    logic       iwr;

    logic       xhit;
    logic [7:0] xphys;
    logic [7:0] xcode_addr;
    logic [7:0] xread;
    logic       xsingle;
    logic       xdouble;

    logic       bus_go;
    logic       flag_clr_en;
    logic [1:0] flag_clr;
    logic [1:0] flag_set;
    logic [1:0] flags_kept;
    logic [1:0] nxt_flags;
    logic [8:0] err_loc;

    assign xprot = |xprot_ff;

    // logical byte address per addressing kind
    always_comb begin
        log_addr = i_int_req.addr;
        int_sfr  = 1'b0;
        unique case (i_int_req.kind)
            ACC_DIRECT: begin
                int_sfr = i_int_req.addr[7];
            end
            ACC_INDIRECT: begin
                int_sfr = 1'b0;
            end
            ACC_BANKREG: begin
                log_addr = {3'h0, i_bank_select_hi, i_bank_select_lo, i_int_req.addr[2:0]};
            end
            ACC_BIT: begin
                log_addr = {BIT_AREA_HI, i_int_req.addr[6:3]};
                int_sfr  = i_int_req.addr[7];
            end
        endcase
    end

    assign iphys      = emap_remap(log_addr, iprot_ff);
    assign icode_addr = iphys | UPPER_BASE;
    assign iacc       = i_int_req.valid & ~int_sfr;

    // plain byte writes read nothing back, so they must not raise flags
    emap_secded u_int_ecc (
        .i_en     (iprot_ff & iacc & (~i_int_req.we | (i_int_req.kind == ACC_BIT))),
        .i_data   (iram_ff[iphys]),
        .i_code   (iram_ff[icode_addr]),
        .o_data   (iread),
        .o_single (isingle),
        .o_double (idouble)
    );

    // bit writes merge into the corrected byte so a stale flip is not kept
    always_comb begin
        iwbyte = i_int_req.wdata;
        if (i_int_req.kind == ACC_BIT) begin
            iwbyte = iread;
            iwbyte[i_int_req.addr[2:0]] = i_int_req.bit_val;
        end
    end

    assign iwr = iacc & i_int_req.we;

    // memory arrays carry no reset; contents are undefined until written
    always_ff @(posedge i_clk) begin
        if (iwr) begin
            iram_ff[iphys] <= iwbyte;
            if (iprot_ff) begin
                iram_ff[icode_addr] <= emap_ecc_encode(iwbyte);
            end
        end
    end

    // same one-cycle answer whether or not the code is checked
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_int_rdata  <= 8'h00;
            o_int_bit    <= 1'b0;
            o_int_rvalid <= 1'b0;
            o_sfr_access <= 1'b0;
        end else begin
            o_int_rvalid <= iacc & ~i_int_req.we;
            o_sfr_access <= i_int_req.valid & int_sfr;
            if (iacc) begin
                o_int_rdata <= iread;
                o_int_bit   <= iread[i_int_req.addr[2:0]];
            end
        end
    end

    // aux ram decode: only external moves reach it
    assign xhit = aux_ram_map_enable_ff & i_x_req.valid &
                  (i_x_req.via_ri | ((i_x_req.page == AUX_PAGE) &
                  (i_x_req.addr[15:8] == 8'h00)));
    assign xphys      = emap_remap(i_x_req.addr[7:0], xprot);
    assign xcode_addr = xphys | UPPER_BASE;

    emap_secded u_aux_ecc (
        .i_en     (xprot & xhit & ~i_x_req.we),
        .i_data   (aux_ram_ff[xphys]),
        .i_code   (aux_ram_ff[xcode_addr]),
        .o_data   (xread),
        .o_single (xsingle),
        .o_double (xdouble)
    );

    always_ff @(posedge i_clk) begin
        if (xhit & i_x_req.we) begin
            aux_ram_ff[xphys] <= i_x_req.wdata;
            if (xprot) begin
                aux_ram_ff[xcode_addr] <= emap_ecc_encode(i_x_req.wdata);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_x_rdata   <= 8'h00;
            o_x_rvalid  <= 1'b0;
            o_ext_rd_b  <= 1'b1;
            o_ext_wr_b  <= 1'b1;
            o_ext_addr  <= 24'h000000;
            o_ext_wdata <= 8'h00;
        end else begin
            o_x_rvalid <= xhit & ~i_x_req.we;
            if (xhit) begin
                o_x_rdata <= xread;
            end
            // a mapped hit never strobes the external bus
            o_ext_rd_b <= ~(i_x_req.valid & ~xhit & ~i_x_req.we);
            o_ext_wr_b <= ~(i_x_req.valid & ~xhit & i_x_req.we);
            if (i_x_req.valid & ~xhit) begin
                o_ext_addr  <= {i_x_req.page, i_x_req.addr};
                o_ext_wdata <= i_x_req.wdata;
            end
        end
    end

    // program space is read only: no write path exists toward it
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_program_store_strobe_b <= 1'b1;
            o_prog_addr              <= 23'h000000;
        end else begin
            o_program_store_strobe_b <= ~i_p_req;
            if (i_p_req) begin
                o_prog_addr <= {i_p_page, 15'h0000} + {7'h00, i_p_addr};
            end
        end
    end

    // avalon-mm slave: one wait cycle, then the access completes
    assign bus_go      = (i_avs_read | i_avs_write) & ~wait_ff;
    assign flag_clr_en = bus_go & i_avs_write & (i_avs_address == OFS_PROT_STAT) &
                         i_avs_byteenable[0];
    assign flag_clr    = flag_clr_en ? i_avs_writedata[1:0] : 2'h0;
    assign flag_set    = {idouble | xdouble, isingle | xsingle};
    assign flags_kept  = flags_ff & ~flag_clr;
    // a new error beats a clear landing in the same cycle
    assign nxt_flags   = flags_kept | flag_set;
    assign err_loc     = (isingle | idouble) ? {1'b0, iphys} : {1'b1, xphys};

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= ~((i_avs_read | i_avs_write) & wait_ff);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            iprot_ff <= PROT_CTRL_RST[PCTL_IPROT_BIT];
            xprot_ff <= PROT_CTRL_RST[PCTL_XPROT_LSB +: 2];
            irqen_ff <= PROT_CTRL_RST[PCTL_IRQEN_BIT];
            aux_ram_map_enable_ff  <= SYS_CTRL_RST;
        end else if (bus_go & i_avs_write & i_avs_byteenable[0]) begin
            if (i_avs_address == OFS_PROT_CTRL) begin
                iprot_ff <= i_avs_writedata[PCTL_IPROT_BIT];
                xprot_ff <= i_avs_writedata[PCTL_XPROT_LSB +: 2];
                irqen_ff <= i_avs_writedata[PCTL_IRQEN_BIT];
            end
            if (i_avs_address == OFS_SYS_CTRL) begin
                aux_ram_map_enable_ff <= i_avs_writedata[SCTL_AUX_RAM_MAP_ENABLE_BIT];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            flags_ff <= ERR_FLAGS_RST;
            eaddr_ff <= ERR_ADDR_RST;
        end else begin
            flags_ff <= nxt_flags;
            // first error wins; later ones leave the capture alone
            if ((flags_kept == 2'h0) && (flag_set != 2'h0)) begin
                eaddr_ff <= err_loc;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_mem_err_irq <= 1'b0;
        end else begin
            o_mem_err_irq <= irqen_ff & (|nxt_flags);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_ff <= 32'h00000000;
        end else if (i_avs_read & wait_ff) begin
            unique case (i_avs_address)
                OFS_PROT_CTRL: rdata_ff <= {28'h0000000, irqen_ff, xprot_ff, iprot_ff};
                OFS_SYS_CTRL:  rdata_ff <= {31'h00000000, aux_ram_map_enable_ff};
                OFS_PROT_STAT: rdata_ff <= {30'h00000000, flags_ff};
                OFS_ERR_ADDR:  rdata_ff <= {23'h000000, eaddr_ff};
                default:       rdata_ff <= 32'h00000000;
            endcase
        end
    end

    assign o_avs_readdata    = rdata_ff;
    assign o_avs_waitrequest = wait_ff;

    property p_sfr_direct;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_int_req.valid && i_int_req.kind == ACC_DIRECT && i_int_req.addr[7])
            |=> (o_sfr_access && !o_int_rvalid);
    endproperty
    a_sfr_direct: assert property (p_sfr_direct)
        else $error("direct access above 7f did not go to special registers");

    property p_bank_reg;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_int_req.valid && i_int_req.kind == ACC_BANKREG)
            |-> (iphys[7:5] == 3'h0 && iphys[4:3] == {i_bank_select_hi, i_bank_select_lo});
    endproperty
    a_bank_reg: assert property (p_bank_reg)
        else $error("register access left the selected bank");

    property p_bit_map;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_int_req.valid && i_int_req.kind == ACC_BIT && !i_int_req.addr[7])
            |-> (iphys == (8'h20 + {4'h0, i_int_req.addr[6:3]}));
    endproperty
    a_bit_map: assert property (p_bit_map)
        else $error("bit address mapped to wrong byte");

    property p_fold;
        @(posedge i_clk) disable iff (!i_rst_b)
        (iprot_ff && iacc) |-> (iphys == {1'b0, log_addr[6:0]});
    endproperty
    a_fold: assert property (p_fold)
        else $error("protected access not folded modulo 80");

    property p_code_write;
        @(posedge i_clk) disable iff (!i_rst_b)
        (iwr && iprot_ff) |=>
            (iram_ff[$past(icode_addr)] == emap_ecc_encode(iram_ff[$past(iphys)]));
    endproperty
    a_code_write: assert property (p_code_write)
        else $error("check code at x+80 does not match stored byte");

    property p_aux_hides_ext;
        @(posedge i_clk) disable iff (!i_rst_b)
        xhit |=> (o_ext_rd_b && o_ext_wr_b && o_x_rvalid == !$past(i_x_req.we));
    endproperty
    a_aux_hides_ext: assert property (p_aux_hides_ext)
        else $error("external bus strobed on a mapped aux access");

    property p_ext_read;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_x_req.valid && !xhit && !i_x_req.we)
            |=> (!o_ext_rd_b && o_ext_addr == {$past(i_x_req.page), $past(i_x_req.addr)});
    endproperty
    a_ext_read: assert property (p_ext_read)
        else $error("external read not strobed at the paged address");

    property p_flags_hold;
        @(posedge i_clk) disable iff (!i_rst_b)
        (flags_ff != 2'h0 && !flag_clr_en)
            |=> (($past(flags_ff) & ~flags_ff) == 2'h0 && $stable(eaddr_ff));
    endproperty
    a_flags_hold: assert property (p_flags_hold)
        else $error("error flags or captured address changed without a clear");

    property p_err_irq;
        @(posedge i_clk) disable iff (!i_rst_b)
        ((isingle || xsingle) && irqen_ff) |=> (flags_ff[0] && o_mem_err_irq)
            ##1 (flags_ff[0] || $past(flag_clr[0]));
    endproperty
    a_err_irq: assert property (p_err_irq)
        else $error("corrected error did not raise flag and request");

    property p_prog_fetch;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_p_req && i_p_page == 8'h00) |=>
            (!o_program_store_strobe_b && o_prog_addr == {7'h00, $past(i_p_addr)});
    endproperty
    a_prog_fetch: assert property (p_prog_fetch)
        else $error("program fetch in page 0 not strobed at its address");

endmodule : emap_top

`default_nettype wire

// ### verification/emap_core_bfm.sv
/* core-side model: issues internal and external move requests.
   assumes the block takes one request at each rising edge. */
`default_nettype none
module emap_core_bfm
    import emap_pkg::*;
(
    input  wire logic         i_clk,
    output var emap_int_req_t o_int_req,
    output var emap_x_req_t   o_x_req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_int_req = '0;
        o_x_req = '0;
    end
    // request stands for the one taking edge only; a refresh is a plain write
    task automatic int_op(input emap_int_req_t r);
        @(posedge i_clk);
        o_int_req <= r;
        @(posedge i_clk);
        o_int_req <= '0;
    endtask : int_op
    // code is never fetched from the aux ram, so no download goes through it
    task automatic x_op(input emap_x_req_t r);
        @(posedge i_clk);
        o_x_req <= r;
        @(posedge i_clk);
        o_x_req <= '0;
    endtask : x_op
endmodule : emap_core_bfm
`default_nettype wire

// ### verification/emap_top_test.sv
/* self-checking bench of emap_top: registers, core moves, fetch, errors.
   assumes emap_core_bfm drives the core side. */
`default_nettype none
module emap_top_test
    import emap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic          clk = 1'b0;
    logic          rst_b = 1'b0;
    logic [3:0]    av_a = 4'h0;
    logic          av_rd = 1'b0;
    logic          av_wr = 1'b0;
    logic [31:0]   av_wd = 32'h0;
    logic [31:0]   av_q;
    logic [31:0]   rv;
    logic          av_wait;
    logic          bk_hi = 1'b0;
    logic          bk_lo = 1'b0;
    logic          p_req = 1'b0;
    logic [7:0]    p_page = 8'h0;
    logic [15:0]   p_addr = 16'h0;
    emap_int_req_t int_req;
    emap_x_req_t   x_req;
    logic [7:0]    int_q;
    logic          int_bit;
    logic          int_v;
    logic          sfr;
    logic [7:0]    x_q;
    logic          x_v;
    logic          ext_rd_b;
    logic          ext_wr_b;
    logic [23:0]   ext_a;
    logic [7:0]    ext_wd;
    logic          ps_b;
    logic [22:0]   prog_a;
    logic          irq;
    logic [23:0]   q_int[$];
    logic [23:0]   q_x[$];
    logic [23:0]   q_ext[$];
    int            n_fail = 0;
    int            compares = 0;
    int            cyc = 0;
    logic [31:0]   seed = 32'h421e;
    logic [7:0]    d;

    always #20 clk = ~clk;

    emap_core_bfm core (.i_clk(clk), .o_int_req(int_req), .o_x_req(x_req));
    emap_top dut (
        .i_clk(clk), .i_rst_b(rst_b), .i_avs_address(av_a), .i_avs_read(av_rd),
        .i_avs_write(av_wr), .i_avs_writedata(av_wd), .i_avs_byteenable(4'hf),
        .o_avs_readdata(av_q), .o_avs_waitrequest(av_wait), .i_int_req(int_req),
        .i_bank_select_hi(bk_hi), .i_bank_select_lo(bk_lo), .o_int_rdata(int_q),
        .o_int_bit(int_bit), .o_int_rvalid(int_v), .o_sfr_access(sfr), .i_x_req(x_req),
        .o_x_rdata(x_q), .o_x_rvalid(x_v), .o_ext_rd_b(ext_rd_b), .o_ext_wr_b(ext_wr_b),
        .o_ext_addr(ext_a), .o_ext_wdata(ext_wd), .i_p_req(p_req), .i_p_page(p_page),
        .i_p_addr(p_addr), .o_program_store_strobe_b(ps_b), .o_prog_addr(prog_a),
        .o_mem_err_irq(irq)
    );

    task automatic tally_and_finish();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic pop(input string nm, ref logic [23:0] q[$], input logic [23:0] g);
        chk({nm, "_pending"}, 24'h1, 24'(q.size() > 0));
        if (q.size() > 0)
            chk(nm, q.pop_front(), g);
    endtask : pop

    // independent model of the chosen check code
    function automatic logic [7:0] ecc_code(input logic [7:0] v);
        logic [4:0] c;
        c[0] = v[0] ^ v[1] ^ v[3] ^ v[4] ^ v[6];
        c[1] = v[0] ^ v[2] ^ v[3] ^ v[5] ^ v[6];
        c[2] = v[1] ^ v[2] ^ v[3] ^ v[7];
        c[3] = ^v[7:4];
        c[4] = ^{v, c[3:0]};
        return {3'h0, c};
    endfunction : ecc_code

    // every answer pulse must match the oldest note; a stray strobe finds none
    always @(negedge clk) begin
        if (int_v === 1'b1)
            pop("int_rdata", q_int, {16'h0, int_q});
        if (x_v === 1'b1)
            pop("x_rdata", q_x, {16'h0, x_q});
        if (ext_rd_b === 1'b0 || ext_wr_b === 1'b0)
            pop("ext_addr", q_ext, ext_a);
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic reg_op(input logic wr, input logic [3:0] a, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge clk);
        av_a <= a;
        av_wd <= v;
        av_wr <= wr;
        av_rd <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (av_wait !== 1'b0 && n < 20);
        chk("waitrequest", 24'h0, {23'h0, av_wait});
        rv = av_q;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
    endtask : reg_op

    task automatic rchk(input logic [3:0] a, input logic [8:0] e, input string nm);
        reg_op(1'b0, a, 32'h0);
        chk(nm, {15'h0, e}, rv[23:0]);
    endtask : rchk

    // m: 0 checked access, 1 special-register space, 2 uncorrectable read, byte as stored
    task automatic io(input logic we, input emap_acc_t k, input logic [7:0] a,
                      input logic [7:0] v, input int m);
        if (!we && m != 1)
            q_int.push_back({16'h0, v});
        core.int_op('{1'b1, we, k, a, v, v[0]});
        @(negedge clk);
        chk("sfr_access", {23'h0, m == 1}, {23'h0, sfr});
        if (!we)
            chk("int_rvalid", {23'h0, m != 1}, {23'h0, int_v});
    endtask : io

    task automatic xo(input logic we, input logic ri, input logic [7:0] pg,
                      input logic [15:0] a, input logic [7:0] v, input logic hit);
        if (hit && !we)
            q_x.push_back({16'h0, v});
        if (!hit)
            q_ext.push_back({pg, a});
        core.x_op('{1'b1, we, ri, a, pg, v});
        @(negedge clk);
        if (we && !hit)
            chk("ext_wdata", {16'h0, v}, {16'h0, ext_wd});
    endtask : xo

    // raw byte with flipped bits and a code for the clean byte, written unprotected
    task automatic plant(input logic aux, input logic [7:0] a, input logic [7:0] f);
        if (aux) begin
            xo(1'b1, 1'b1, 8'h0, {8'h0, a}, d ^ f, 1'b1);
            xo(1'b1, 1'b1, 8'h0, {8'h0, a | 8'h80}, ecc_code(d), 1'b1);
        end else begin
            io(1'b1, ACC_INDIRECT, a, d ^ f, 0);
            io(1'b1, ACC_INDIRECT, a | 8'h80, ecc_code(d), 0);
        end
    endtask : plant

    initial begin
        logic [7:0] bits [3];
        repeat (4) @(posedge clk);
        chk("wait_in_reset", 24'h1, {23'h0, av_wait});
        rst_b <= 1'b1;
        for (int i = 0; i < 16; i += 4)
            rchk(4'(i), 9'h0, "reg_reset");
        rchk(4'h2, 9'h0, "unmapped");
        d = 8'($random(seed));
        io(1'b1, ACC_DIRECT, 8'h40, d, 0);
        io(1'b0, ACC_INDIRECT, 8'h40, d, 0);
        io(1'b1, ACC_INDIRECT, 8'h9a, ~d, 0);
        io(1'b0, ACC_INDIRECT, 8'h9a, ~d, 0);
        io(1'b0, ACC_DIRECT, 8'h9a, 8'h0, 1);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {bk_hi, bk_lo} <= 2'(i);
            io(1'b1, ACC_BANKREG, 8'h03, d + 8'(i), 0);
            io(1'b0, ACC_INDIRECT, 8'(8 * i + 3), d + 8'(i), 0);
        end
        bits = '{8'h00, 8'h7f, 8'($random(seed)) & 8'h7f};
        foreach (bits[j]) begin
            io(1'b1, ACC_INDIRECT, 8'h20 + {4'h0, bits[j][6:3]}, 8'h0, 0);
            io(1'b1, ACC_BIT, bits[j], 8'h1, 0);
            io(1'b0, ACC_INDIRECT, 8'h20 + {4'h0, bits[j][6:3]}, 8'h1 << bits[j][2:0], 0);
            io(1'b0, ACC_BIT, bits[j], 8'h1 << bits[j][2:0], 0);
            chk("int_bit", 24'h1, {23'h0, int_bit});
        end
        xo(1'b1, 1'b0, 8'h03, 16'h1234, d, 1'b0);
        xo(1'b1, 1'b0, 8'h00, 16'h0010, d, 1'b0);
        reg_op(1'b1, OFS_SYS_CTRL, 32'h1);
        xo(1'b1, 1'b1, 8'h05, 16'hff55, d, 1'b1);
        xo(1'b0, 1'b0, 8'h00, 16'h0055, d, 1'b1);
        xo(1'b0, 1'b0, 8'h01, 16'h0055, d, 1'b0);
        xo(1'b0, 1'b0, 8'h00, 16'h0155, d, 1'b0);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            p_page <= 8'(2 * i);
            p_addr <= 16'h0100;
            p_req <= 1'b1;
            @(posedge clk);
            p_req <= 1'b0;
            @(negedge clk);
            chk("prog_strobe_b", 24'h0, {23'h0, ps_b});
            chk("prog_addr", {7'h0, i[0], 16'h0100}, {1'h0, prog_a});
        end
        d = 8'($random(seed));
        plant(1'b0, 8'h05, 8'h01);
        plant(1'b0, 8'h06, 8'h03);
        plant(1'b1, 8'h07, 8'h01);
        reg_op(1'b1, OFS_PROT_CTRL, 32'h9);
        io(1'b0, ACC_INDIRECT, 8'h85, d, 0);
        chk("irq", 24'h1, {23'h0, irq});
        rchk(OFS_PROT_STAT, 9'h1, "err_flags");
        rchk(OFS_ERR_ADDR, 9'h005, "err_addr");
        io(1'b0, ACC_INDIRECT, 8'h06, d ^ 8'h03, 2);
        rchk(OFS_PROT_STAT, 9'h3, "err_flags");
        rchk(OFS_ERR_ADDR, 9'h005, "err_addr");
        io(1'b1, ACC_INDIRECT, 8'h05, d, 0);
        reg_op(1'b1, OFS_PROT_STAT, 32'h3);
        rchk(OFS_PROT_STAT, 9'h0, "err_flags");
        io(1'b0, ACC_INDIRECT, 8'h05, d, 0);
        chk("irq", 24'h0, {23'h0, irq});
        reg_op(1'b1, OFS_PROT_CTRL, 32'h4);
        xo(1'b0, 1'b1, 8'h00, 16'h0087, d, 1'b1);
        rchk(OFS_PROT_STAT, 9'h1, "err_flags");
        rchk(OFS_ERR_ADDR, 9'h107, "err_addr");
        chk("irq_masked", 24'h0, {23'h0, irq});
        chk("notes_left", 24'h0, 24'(q_int.size() + q_x.size() + q_ext.size()));
        tally_and_finish();
    end
endmodule : emap_top_test
`default_nettype wire
